// >>> verilog/lprs_cfg.svh
`ifndef LPRS_CFG_SVH
`define LPRS_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LPRS_OFF_BREAK_STATUS  16'hfe00
`define LPRS_OFF_RESET_CAUSE   16'hfe01
`define LPRS_OFF_BREAK_FLAG    16'hfe03
`define LPRS_OFF_CONFIG        16'hfe04
// ----------------------------------------
// Field positions
// ----------------------------------------
`define LPRS_BIT_BSW           1
`define LPRS_BIT_CLR_EN        7
`define LPRS_BIT_LOWV          1
`define LPRS_BIT_MOD           2
`define LPRS_BIT_BADFETCH      3
`define LPRS_BIT_BADOP         4
`define LPRS_BIT_WDOG          5
`define LPRS_BIT_PIN           6
`define LPRS_BIT_POR           7
`define LPRS_BIT_SHORT         0
`define LPRS_BIT_OSCKEEP       1
`define LPRS_BIT_WDDIS         2
// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define LPRS_RST_BYTE          8'h00
`define LPRS_REC_LONG          13'h1000
`define LPRS_REC_SHORT         13'h0020
`endif

// >>> verilog/lprs_pkg.sv
package lprs_pkg;
	typedef enum logic [1:0] {LPRS_RUN, LPRS_WAIT, LPRS_STOP, LPRS_RECOVER} lprs_mode_t;
endpackage : lprs_pkg

// >>> verilog/lprs_top.sv
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "lprs_cfg.svh"
module lprs_top
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [15:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [15:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        wait_exec,
	input  wire logic        stop_exec,
	input  wire logic        irq_req,
	input  wire logic        break_req,
	input  wire logic        por_event,
	input  wire logic        pin_reset_event,
	input  wire logic        watchdog_reset_event,
	input  wire logic        bad_opcode_event,
	input  wire logic        bad_fetch_event,
	input  wire logic        monitor_entry_event,
	input  wire logic        low_voltage_event,
	output logic             cpu_clk_en,
	output logic             periph_clk_en,
	output logic             fast_clk_en,
	output logic             stack_start,
	output logic             imask_clear,
	output logic             watchdog_run,
	output logic             flag_clear_allow,
	output logic             in_break
);
	// ----------------------------------------
	// Input synchronisers for asynchronous events
	// ----------------------------------------
	logic [10:0] ev_s1_q;
	logic [10:0] ev_s2_q;
	logic [10:0] ev_raw;
	assign ev_raw = {low_voltage_event, monitor_entry_event, bad_fetch_event, bad_opcode_event,
		watchdog_reset_event, pin_reset_event, por_event, break_req, irq_req, stop_exec, wait_exec};
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ev_s1_q <= 11'h000;
			ev_s2_q <= 11'h000;
		end
		else
		begin
			ev_s1_q <= ev_raw;
			ev_s2_q <= ev_s1_q;
		end
	end
	logic wait_i;
	logic stop_i;
	logic irq_i;
	logic brk_i;
	logic por_i;
	logic pin_i;
	logic wd_i;
	logic badop_i;
	logic badfetch_i;
	logic mod_i;
	logic lowv_i;
	assign {lowv_i, mod_i, badfetch_i, badop_i, wd_i, pin_i, por_i, brk_i, irq_i, stop_i, wait_i} = ev_s2_q;
	logic any_reset;
	assign any_reset = por_i | pin_i | wd_i | badop_i | badfetch_i | mod_i | lowv_i;
	// ----------------------------------------
	// Configuration and break control registers
	// ----------------------------------------
	logic [7:0] cfg_q;
	logic [7:0] brk_ctl_q;
	logic [7:0] brk_stat_q;
	logic [7:0] cause_q;
	logic       short_rec;
	logic       osc_keep;
	assign short_rec = cfg_q[`LPRS_BIT_SHORT];
	assign osc_keep  = cfg_q[`LPRS_BIT_OSCKEEP];
	// ----------------------------------------
	// Low-power sequencer
	// ----------------------------------------
	lprs_pkg::lprs_mode_t mode_q;
	logic [12:0] seq_cnt_q;
	logic [12:0] rec_target;
	logic        stack_q;
	assign rec_target = short_rec ? `LPRS_REC_SHORT : `LPRS_REC_LONG;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_q <= lprs_pkg::LPRS_RUN;
			stack_q <= 1'b0;
		end
		else
		begin
			stack_q <= 1'b0;
			case (mode_q)
				lprs_pkg::LPRS_RUN:
				begin
					if (stop_i)
						mode_q <= lprs_pkg::LPRS_STOP;
					else if (wait_i)
						mode_q <= lprs_pkg::LPRS_WAIT;
				end
				lprs_pkg::LPRS_WAIT:
				begin
					if (irq_i || brk_i || any_reset)
					begin
						mode_q <= lprs_pkg::LPRS_RUN;
						stack_q <= irq_i | brk_i;
					end
				end
				lprs_pkg::LPRS_STOP:
				begin
					if (irq_i || brk_i || any_reset)
						mode_q <= lprs_pkg::LPRS_RECOVER;
				end
				lprs_pkg::LPRS_RECOVER:
				begin
					if (seq_cnt_q >= rec_target - 13'h0001)
					begin
						mode_q <= lprs_pkg::LPRS_RUN;
						stack_q <= 1'b1;
					end
				end
				default:
					mode_q <= lprs_pkg::LPRS_RUN;
			endcase
		end
	end
	// Counter held clear until recovery; times the interval
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			seq_cnt_q <= 13'h0000;
		else if (mode_q == lprs_pkg::LPRS_RECOVER)
			seq_cnt_q <= seq_cnt_q + 13'h0001;
		else
			seq_cnt_q <= 13'h0000;
	end
	// Clock gating follows mode directly
	assign cpu_clk_en    = (mode_q == lprs_pkg::LPRS_RUN);
	assign periph_clk_en = (mode_q == lprs_pkg::LPRS_RUN) || (mode_q == lprs_pkg::LPRS_WAIT);
	// Fast clock must run during recovery to time it
	assign fast_clk_en   = (mode_q != lprs_pkg::LPRS_STOP) || osc_keep;
	assign stack_start   = stack_q;
	assign imask_clear   = (mode_q == lprs_pkg::LPRS_RUN) && (wait_i || stop_i);
	assign watchdog_run  = !cfg_q[`LPRS_BIT_WDDIS] && (mode_q != lprs_pkg::LPRS_STOP);
	// ----------------------------------------
	// Break tracking
	// ----------------------------------------
	logic brk_q;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			brk_q <= 1'b0;
		else if (brk_i)
			brk_q <= 1'b1;
		else if (stack_q || any_reset)
			brk_q <= 1'b0;
	end
	assign in_break = brk_q;
	// Protection only gates clears; a cleared flag stays cleared
	assign flag_clear_allow = !brk_q || brk_ctl_q[`LPRS_BIT_CLR_EN];
	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	logic        aw_hold_q;
	logic        w_hold_q;
	logic [15:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [1:0]  rresp_q;
	logic [31:0] rdata_q;
	logic        wr_fire;
	logic        rd_fire;
	logic        wr_ok;
	logic        lane0;
	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready  = !w_hold_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_q <= 1'b0;
			awaddr_q <= 16'h0000;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_hold_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end
		else if (wr_fire)
			aw_hold_q <= 1'b0;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_hold_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_hold_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end
		else if (wr_fire)
			w_hold_q <= 1'b0;
	end
	// Register word is aligned; all four offsets FE00-FE04 are word indices, shifted left two to form the byte address
	logic [15:0] waddr_w;
	logic [15:0] raddr_w;
	assign waddr_w = {awaddr_q[15:2], 2'b00};
	assign raddr_w = {s_axi_araddr[15:2], 2'b00};
	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		hit = (a == {off[13:0], 2'b00});
	endfunction : hit
	assign lane0 = wstrb_q[0];
	assign wr_ok = hit(waddr_w, `LPRS_OFF_BREAK_STATUS) || hit(waddr_w, `LPRS_OFF_RESET_CAUSE)
		|| hit(waddr_w, `LPRS_OFF_BREAK_FLAG) || hit(waddr_w, `LPRS_OFF_CONFIG);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= 2'b00;
		end
		else if (wr_fire)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_ok ? 2'b00 : 2'b10;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg_q <= `LPRS_RST_BYTE;
			brk_ctl_q <= `LPRS_RST_BYTE;
		end
		else if (wr_fire && lane0)
		begin
			if (hit(waddr_w, `LPRS_OFF_BREAK_FLAG))
				brk_ctl_q <= wdata_q[7:0] & (8'h01 << `LPRS_BIT_CLR_EN);
			if (hit(waddr_w, `LPRS_OFF_CONFIG))
				cfg_q <= wdata_q[7:0] & 8'h07;
		end
	end
	// Break status: set on break in low power, software writes zero to clear
	logic brk_stat_clr;
	assign brk_stat_clr = wr_fire && lane0 && hit(waddr_w, `LPRS_OFF_BREAK_STATUS)
		&& !wdata_q[`LPRS_BIT_BSW];
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			brk_stat_q <= `LPRS_RST_BYTE;
		else if (brk_i && (mode_q == lprs_pkg::LPRS_WAIT || mode_q == lprs_pkg::LPRS_STOP))
			brk_stat_q[`LPRS_BIT_BSW] <= 1'b1;
		else if (brk_stat_clr)
			brk_stat_q[`LPRS_BIT_BSW] <= 1'b0;
	end
	// ----------------------------------------
	// Reset cause status
	// ----------------------------------------
	// Bus reset does not clear causes; only power-on and reads do
	logic       cause_rd;
	logic [7:0] cause_set;
	assign cause_rd = rd_fire && hit(raddr_w, `LPRS_OFF_RESET_CAUSE);
	always_comb
	begin
		cause_set = 8'h00;
		cause_set[`LPRS_BIT_PIN]      = pin_i;
		cause_set[`LPRS_BIT_WDOG]     = wd_i;
		cause_set[`LPRS_BIT_BADOP]    = badop_i;
		cause_set[`LPRS_BIT_LOWV]     = lowv_i;
		cause_set[`LPRS_BIT_BADFETCH] = badfetch_i;
		cause_set[`LPRS_BIT_MOD]      = mod_i;
	end
	always_ff @(posedge aclk)
	begin
		if (por_i)
			cause_q <= (8'h01 << `LPRS_BIT_POR) | cause_set;
		else if (!aresetn)
			cause_q <= cause_q;
		else if (cause_rd)
			cause_q <= cause_set;
		else
			cause_q <= cause_q | cause_set;
	end
	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rresp_q <= 2'b00;
			rdata_q <= 32'h0000_0000;
		end
		else if (rd_fire)
		begin
			rvalid_q <= 1'b1;
			rresp_q <= 2'b00;
			rdata_q <= 32'h0000_0000;
			if (hit(raddr_w, `LPRS_OFF_BREAK_STATUS))
				rdata_q[7:0] <= brk_stat_q;
			else if (hit(raddr_w, `LPRS_OFF_RESET_CAUSE))
				rdata_q[7:0] <= cause_q;
			else if (hit(raddr_w, `LPRS_OFF_BREAK_FLAG))
				rdata_q[7:0] <= brk_ctl_q;
			else if (hit(raddr_w, `LPRS_OFF_CONFIG))
				rdata_q[7:0] <= cfg_q;
			else
				rresp_q <= 2'b10;
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp  = rresp_q;
	assign s_axi_rdata  = rdata_q;
endmodule : lprs_top

// >>> tb/lprs_asserts.sv
`timescale 1ns/1ps
module lprs_asserts
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        wait_exec,
	input wire logic        stop_exec,
	input wire logic        irq_req,
	input wire logic        cpu_clk_en,
	input wire logic        periph_clk_en,
	input wire logic        stack_start,
	input wire logic        imask_clear,
	input wire logic        watchdog_run,
	input wire logic        flag_clear_allow,
	input wire logic        in_break
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ------
	// Bus and modes
	// ------
	chk_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answered twice");
	chk_wait_entry: assert property
		($rose(wait_exec) && cpu_clk_en && !stop_exec |-> ##[1:6] !cpu_clk_en && periph_clk_en)
		else $error("wait not entered");
	chk_irq_wakes: assert property ($rose(irq_req) && !cpu_clk_en && periph_clk_en |-> ##[1:4] stack_start)
		else $error("no wake from wait");
	chk_stack_run: assert property (stack_start |-> ##[0:1] cpu_clk_en)
		else $error("stacking without clock");
	chk_stop_entry: assert property ($rose(stop_exec) && cpu_clk_en |-> ##[1:6] !cpu_clk_en && !periph_clk_en)
		else $error("stop not entered");
	chk_mask_clear: assert property (($rose(wait_exec) || $rose(stop_exec)) && cpu_clk_en |-> ##[1:5] imask_clear)
		else $error("mask not cleared");
	// Bench sets the watchdog disable bit only while running
	chk_wdog_wait: assert property (!cpu_clk_en && periph_clk_en |-> watchdog_run)
		else $error("watchdog stopped in wait");
	chk_allow_free: assert property (!in_break |-> flag_clear_allow)
		else $error("clear blocked outside break");
endmodule : lprs_asserts

bind lprs_top lprs_asserts u_chk
(
	.aclk             (aclk),
	.aresetn          (aresetn),
	.s_axi_rvalid     (s_axi_rvalid),
	.s_axi_rready     (s_axi_rready),
	.wait_exec        (wait_exec),
	.stop_exec        (stop_exec),
	.irq_req          (irq_req),
	.cpu_clk_en       (cpu_clk_en),
	.periph_clk_en    (periph_clk_en),
	.stack_start      (stack_start),
	.imask_clear      (imask_clear),
	.watchdog_run     (watchdog_run),
	.flag_clear_allow (flag_clear_allow),
	.in_break         (in_break)
);

// >>> tb/lprs_partner.sv
`timescale 1ns/1ps
module lprs_partner
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [10:0] go,
	input  wire logic        stack_start,
	output logic             wait_exec = 1'b0,
	output logic             stop_exec = 1'b0,
	output logic             irq_req = 1'b0,
	output logic             break_req = 1'b0,
	output logic             por_event = 1'b0,
	output logic             pin_reset_event = 1'b0,
	output logic             watchdog_reset_event = 1'b0,
	output logic             bad_opcode_event = 1'b0,
	output logic             bad_fetch_event = 1'b0,
	output logic             monitor_entry_event = 1'b0,
	output logic             low_voltage_event = 1'b0
);
	// ------
	// Core and reset sources
	// ------
	// One-cycle pulses, as an instruction or a reset source gives them
	always @(posedge aclk)
	begin
		{break_req, stop_exec, wait_exec, por_event, pin_reset_event, watchdog_reset_event, bad_opcode_event,
			bad_fetch_event, monitor_entry_event, low_voltage_event} <= aresetn ? {go[10], go[8:0]} : 10'h000;
	end
	// Request held until stacked, so a slow wake is not lost
	always @(posedge aclk)
	begin
		if (!aresetn || stack_start)
			irq_req <= 1'b0;
		else if (go[9])
			irq_req <= 1'b1;
	end
endmodule : lprs_partner

// >>> tb/lprs_bench.sv
`timescale 1ns/1ps
module lprs_bench;
	localparam logic [15:0] a_brk = 16'hf800;
	localparam logic [15:0] a_cause = 16'hf804;
	localparam logic [15:0] a_bctl = 16'hf80c;
	localparam logic [15:0] a_cfg = 16'hf810;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h1;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        wait_exec, stop_exec, irq_req, break_req, por_event, pin_reset_event, watchdog_reset_event;
	logic        bad_opcode_event, bad_fetch_event, monitor_entry_event, low_voltage_event;
	logic        cpu_clk_en, periph_clk_en, fast_clk_en, stack_start, imask_clear;
	logic        watchdog_run, flag_clear_allow, in_break, keep;
	logic [10:0] go = 11'h000;
	int          miscompares = 0, n_tests = 0, n, rec;

	lprs_top DUT (.*);
	lprs_partner u_far (.*);

	always #5 aclk = ~aclk;
	// ------
	// Tasks
	// ------
	task automatic stop_test;
		$display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	task automatic tmo;
		miscompares++;
		$display("Error at %0t: wait ran out", $time);
		stop_test;
	endtask : tmo
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic span(input int got, input int lo, input int hi);
		n_tests++;
		if (got < lo || got > hi)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, lo);
		end
	endtask : span
	function automatic logic [1:0] exp_resp(input logic [15:0] a);
		exp_resp = (a == a_brk || a == a_cause || a == a_bctl || a == a_cfg) ? 2'b00 : 2'b10;
	endfunction : exp_resp
	task automatic idle(input int c);
		repeat (c) @(posedge aclk);
	endtask : idle
	task automatic pulse(input int k);
		@(posedge aclk);
		go <= 11'h001 << k;
		@(posedge aclk);
		go <= 11'h000;
	endtask : pulse
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		int c;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		c = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			c++;
		end
		while (s_axi_bvalid !== 1'b1 && c < 200);
		s_axi_bready <= 1'b0;
		if (c >= 200)
			tmo;
		cmp({30'h0000_0000, s_axi_bresp}, {30'h0000_0000, exp_resp(a)});
	endtask : wr
	task automatic rdc(input logic [15:0] a, input logic [7:0] e, input logic [1:0] r);
		int c;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		c = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			c++;
		end
		while (s_axi_rvalid !== 1'b1 && c < 200);
		s_axi_rready <= 1'b0;
		if (c >= 200)
			tmo;
		cmp(s_axi_rdata, {24'h00_0000, e});
		cmp({30'h0000_0000, s_axi_rresp}, {30'h0000_0000, r});
	endtask : rdc
	task automatic until_run(output int c);
		for (c = 0; c < 5000 && cpu_clk_en !== 1'b1; c++)
			@(posedge aclk);
		if (c >= 5000)
			tmo;
	endtask : until_run
	// ------
	// Sequence
	// ------
	initial
	begin
		void'($urandom(32'h558c));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		pulse(6);
		idle(4);
		rdc(a_cause, 8'h80, 2'b00);
		rdc(a_cause, 8'h00, 2'b00);
		for (int k = 0; k < 6; k++)
		begin
			pulse(k);
			idle(4);
			rdc(a_cause, 8'h01 << (k + 1), 2'b00);
		end
		pulse(5);
		pulse(6);
		idle(4);
		rdc(a_cause, 8'h80, 2'b00);
		pulse(6);
		pulse(5);
		idle(4);
		rdc(a_cause, 8'hc0, 2'b00);
		rdc(16'hf808, 8'h00, 2'b10);
		wr(16'hf808, 8'h5a);
		wr(a_bctl, 8'h80);
		rdc(a_bctl, 8'h80, 2'b00);
		wr(a_bctl, 8'h00);
		pulse(10);
		idle(4);
		cmp(in_break, 1'b1);
		cmp(flag_clear_allow, 1'b0);
		rdc(a_brk, 8'h00, 2'b00);
		wr(a_bctl, 8'h80);
		cmp(flag_clear_allow, 1'b1);
		wr(a_bctl, 8'h00);
		cmp(flag_clear_allow, 1'b0);
		pulse(0);
		idle(4);
		cmp(in_break, 1'b0);
		cmp(flag_clear_allow, 1'b1);
		rdc(a_cause, 8'h02, 2'b00);
		pulse(7);
		idle(6);
		cmp(cpu_clk_en, 1'b0);
		cmp(periph_clk_en, 1'b1);
		cmp(watchdog_run, 1'b1);
		pulse(10);
		until_run(n);
		rdc(a_brk, 8'h02, 2'b00);
		wr(a_brk, 8'h00);
		rdc(a_brk, 8'h00, 2'b00);
		pulse(7);
		idle($urandom_range(6, 20));
		pulse(9);
		until_run(n);
		span(n, 0, 4);
		for (int i = 0; i < 3; i++)
		begin
			keep = 1'($urandom_range(0, 1));
			rec = (i < 2) ? 32 : 4096;
			wr(a_cfg, {6'h00, keep, i < 2});
			pulse(8);
			idle(6);
			cmp(periph_clk_en, 1'b0);
			cmp(fast_clk_en, keep);
			pulse((i == 1) ? 10 : 9);
			until_run(n);
			span(n, rec, rec + 8);
		end
		rdc(a_brk, 8'h02, 2'b00);
		wr(a_cfg, 8'h04);
		rdc(a_cfg, 8'h04, 2'b00);
		cmp(watchdog_run, 1'b0);
		wr(a_cfg, 8'h00);
		cmp(watchdog_run, 1'b1);
		stop_test;
	end
endmodule : lprs_bench
